/* File: hdl/ufec_pkg.sv */
// constants, codes and types shared by both ends of the function event control link
package ufec_pkg;
    localparam int CLK_MHZ = 50;
    localparam int SUSPEND_IDLE_US = 3000;
    localparam int SUSPEND_IDLE_CYCLES = SUSPEND_IDLE_US * CLK_MHZ;
    localparam int REG_SETTLE_US = 3;
    localparam int REG_SETTLE_CYCLES = REG_SETTLE_US * CLK_MHZ;

    // register offsets on the cpu port
    localparam logic [2:0] REG_EVENT_FLAGS = 3'h0;
    localparam logic [2:0] REG_EVENT_ENABLES = 3'h1;
    localparam logic [2:0] REG_LINK_CONTROL = 3'h2;
    localparam logic [2:0] REG_NODE_ID = 3'h3;
    localparam logic [2:0] REG_TRANSFER_STATUS = 3'h4;
    localparam logic [2:0] REG_CONTROL_PIPE = 3'h5;

    // values after reset, and masks of the writable enable bits and the main interrupt bits
    localparam logic [7:0] EVENT_FLAGS_RST = 8'h00;
    localparam logic [7:0] EVENT_ENABLES_RST = 8'h00;
    localparam logic [7:0] LINK_CONTROL_RST = 8'h06;
    localparam logic [7:0] ENABLE_WRITABLE = 8'hbf;
    localparam logic [7:0] MAIN_VECTOR_BITS = 8'hbb;

    // event flag positions
    localparam int EV_GOOD = 7;
    localparam int EV_SOVR = 5;
    localparam int EV_FAULT = 4;
    localparam int EV_IDLE = 3;
    localparam int EV_WAKE = 2;
    localparam int EV_RESET = 1;
    localparam int EV_SOF = 0;

    // token pids
    localparam logic [3:0] PID_OUT = 4'h1;
    localparam logic [3:0] PID_IN = 4'h9;
    localparam logic [3:0] PID_SETUP = 4'hd;

    // directional pipe states
    localparam logic [1:0] STAT_DISABLED = 2'h0;
    localparam logic [1:0] STAT_STALL = 2'h1;
    localparam logic [1:0] STAT_NAK = 2'h2;
    localparam logic [1:0] STAT_VALID = 2'h3;

    // answers from the device back to the host
    typedef enum logic [2:0] {
        ANS_ACK = 3'h0,
        ANS_NAK = 3'h1,
        ANS_STALL = 3'h2,
        ANS_DATA0 = 3'h3,
        ANS_DATA1 = 3'h4
    } ufec_ans_t;

    // kinds of item the host puts on the link
    typedef enum logic [2:0] {
        KIND_TOKEN = 3'h0,
        KIND_DATA = 3'h1,
        KIND_ACK = 3'h2,
        KIND_ERR = 3'h3,
        KIND_SOF = 3'h4
    } ufec_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DATA = 3'b010,
        ST_ACK = 3'b100
    } ufec_state_t;
endpackage

/* File: hdl/ufec_link_if.sv */
// link between the host controller end and the function end
`timescale 1ns/10ps
interface ufec_link_if;
    import ufec_pkg::*;
    logic tokValid;
    logic [3:0] tokPid;
    logic [6:0] tokAddr;
    logic [1:0] tokEp;
    logic dataValid;
    logic dataPid1;
    logic dataGood;
    logic hostAck;
    logic sofValid;
    logic errValid;
    logic [2:0] errCode;
    logic lineIdle;
    logic resetSeq;
    logic resumeSeq;
    logic ansValid;
    ufec_ans_t ansKind;
    logic resumeDrive;
    logic regOff;

    modport dev (
        input tokValid, tokPid, tokAddr, tokEp, dataValid, dataPid1, dataGood, hostAck,
        input sofValid, errValid, errCode, lineIdle, resetSeq, resumeSeq,
        output ansValid, ansKind, resumeDrive, regOff
    );
    modport host (
        output tokValid, tokPid, tokAddr, tokEp, dataValid, dataPid1, dataGood, hostAck,
        output sofValid, errValid, errCode, lineIdle, resetSeq, resumeSeq,
        input ansValid, ansKind, resumeDrive, regOff
    );
endinterface

/* File: hdl/ufec_device.sv */
// function end: event flags, link control, node address, status and control pipe
`timescale 1ns/10ps
module ufec_device
    import ufec_pkg::*;
#(
    parameter int IDLE_CYCLES = SUSPEND_IDLE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    ufec_link_if.dev link,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic cpuIntMask,
    input wire logic pipeCtrPending,
    input wire logic pipeDone,
    input wire logic [1:0] pipeDoneEp,
    input wire logic pipeDoneIn,
    output logic irqMain,
    output logic irqWake,
    output logic pipeReset
);
    localparam int CW = $clog2(IDLE_CYCLES + 2);
    localparam logic [CW-1:0] CNT_HIT = CW'(IDLE_CYCLES);
    localparam logic [CW-1:0] CNT_TOP = CW'(IDLE_CYCLES + 1);
    localparam logic [7:0] SETTLE_LOAD = 8'(REG_SETTLE_CYCLES);

    logic [5:0] flags_r;
    logic [7:0] enables_r;
    logic resumeSeen_r, rstSeen_r, resumeBit_r, regOff_r, forceSleep_r, forceReset_r;
    logic [6:0] nodeId_r;
    logic [1:0] statPid_r, statEp_r;
    logic statDir_r;
    logic [2:0] statErr_r;
    logic pDone_r, txTog_r, rxTog_r;
    logic [1:0] txStat_r, rxStat_r;
    logic detEn_r, waking_r;
    logic [CW-1:0] idleCnt_r;
    logic resetSeqD_r, forceResetD_r;
    logic [7:0] settle_r;
    ufec_state_t state_r, state_nxt;
    logic isSetup_r, isSetup_nxt;
    logic [3:0] curPid_r;
    logic ansValid_r, ansValid_nxt;
    ufec_ans_t ansKind_r, ansKind_nxt;
    logic [7:0] regRdata_r;
    logic doneEv, setupEv, rxFlip, txFlip, stallSet;
    logic wrFlags, wrEn, wrCtl, wrNode, wrPipe;
    logic linkReset, busResetEv, wakeEv, suspEv, sovrEv, accept;
    logic [7:0] flagView;

    ////////////////////////////////////////////////////////////////////////////
    // decode and event terms
    assign wrFlags = regWr && (regAddr == REG_EVENT_FLAGS);
    assign wrEn = regWr && (regAddr == REG_EVENT_ENABLES);
    assign wrCtl = regWr && (regAddr == REG_LINK_CONTROL);
    assign wrNode = regWr && (regAddr == REG_NODE_ID);
    assign wrPipe = regWr && (regAddr == REG_CONTROL_PIPE);
    assign linkReset = link.resetSeq | forceReset_r;
    assign pipeReset = linkReset;
    // a reset is flagged on the line edge and again on release of the forced hold
    assign busResetEv = (link.resetSeq & ~resetSeqD_r) | (forceResetD_r & ~forceReset_r);
    assign wakeEv = forceSleep_r & ~link.lineIdle;
    assign suspEv = detEn_r & link.lineIdle & (idleCnt_r == CNT_HIT);
    assign sovrEv = setupEv & pDone_r;
    // tokens are ignored while held in reset, asleep, or while the regulator settles
    assign accept = link.tokValid && (link.tokAddr == nodeId_r) && (link.tokEp == 2'h0)
        && !linkReset && !forceSleep_r && !regOff_r && (settle_r == 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    // edge history of the reset sources
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            resetSeqD_r <= 1'b0;
            forceResetD_r <= 1'b0;
        end else begin
            resetSeqD_r <= link.resetSeq;
            forceResetD_r <= forceReset_r;
        end
    end

    // idle timer; saturates past the hit so the flag is raised once per idle stretch
    always_ff @(posedge clk_sys) begin
        if (rst || !link.lineIdle || !detEn_r) begin
            idleCnt_r <= '0;
        end else if (idleCnt_r != CNT_TOP) begin
            idleCnt_r <= idleCnt_r + CW'(1);
        end
    end

    // idle detection armed by a bus reset event, dropped on forced sleep, rearmed after resume
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            detEn_r <= 1'b0;
            waking_r <= 1'b0;
        end else begin
            if (wakeEv || (wrCtl && !regWdata[1] && forceSleep_r)) begin
                waking_r <= 1'b1;
            end else if (waking_r && !link.resumeSeq && !resumeBit_r) begin
                waking_r <= 1'b0;
                detEn_r <= 1'b1;
            end
            if (wrCtl && regWdata[1]) begin
                detEn_r <= 1'b0;
                waking_r <= 1'b0;
            end
            if (busResetEv) begin
                detEn_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event flags: a written zero clears, hardware set in the same cycle wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags_r <= EVENT_FLAGS_RST[5:0];
        end else begin
            flags_r <= (wrFlags ? (flags_r & regWdata[5:0]) : flags_r)
                | {sovrEv, link.errValid, suspEv, wakeEv, busResetEv,
                   link.sofValid & ~linkReset};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enables_r <= EVENT_ENABLES_RST;
        end else if (wrEn) begin
            enables_r <= regWdata & ENABLE_WRITABLE;
        end
    end

    // the good-transfer flag is the or of all pipe done bits, not stored here
    assign flagView = {pDone_r | pipeCtrPending, 1'b0, flags_r};
    assign irqMain = (|(flagView & enables_r & MAIN_VECTOR_BITS)) & ~cpuIntMask;
    assign irqWake = flagView[EV_WAKE] & enables_r[EV_WAKE] & ~cpuIntMask;

    ////////////////////////////////////////////////////////////////////////////
    // link control bits
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {resumeSeen_r, rstSeen_r} <= LINK_CONTROL_RST[7:6];
            {resumeBit_r, regOff_r, forceSleep_r, forceReset_r} <= LINK_CONTROL_RST[3:0];
        end else begin
            if (wrCtl) begin
                {resumeBit_r, regOff_r, forceSleep_r, forceReset_r} <= regWdata[3:0];
                if (regWdata[1] && !forceSleep_r) begin
                    {resumeSeen_r, rstSeen_r} <= 2'h0;
                end
            end
            if (wakeEv) begin
                forceSleep_r <= 1'b0;
                resumeSeen_r <= link.resumeSeq;
                rstSeen_r <= link.resetSeq;
            end
        end
    end

    assign link.resumeDrive = resumeBit_r;
    assign link.regOff = regOff_r;

    // after the regulator comes back, the link stays deaf until supply settles
    always_ff @(posedge clk_sys) begin
        if (rst || regOff_r) begin
            settle_r <= SETTLE_LOAD;
        end else if (settle_r != 8'h00) begin
            settle_r <= settle_r - 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || linkReset) begin
            nodeId_r <= 7'h00;
        end else if (wrNode) begin
            nodeId_r <= regWdata[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transfer status; left alone on a setup overrun
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {statPid_r, statDir_r, statEp_r, statErr_r} <= 8'h00;
        end else begin
            if (doneEv && !sovrEv) begin
                statPid_r <= curPid_r[3:2];
                statEp_r <= 2'h0;
            end
            if (pipeDone) begin
                statDir_r <= pipeDoneIn;
                statEp_r <= pipeDoneEp;
            end
            if (link.errValid) begin
                statErr_r <= link.errCode;
            end else if (wrFlags && !regWdata[EV_FAULT]) begin
                statErr_r <= 3'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control pipe transaction sequencer
    always_comb begin
        state_nxt = state_r;
        isSetup_nxt = isSetup_r;
        ansValid_nxt = 1'b0;
        ansKind_nxt = ANS_NAK;
        {doneEv, setupEv, rxFlip, txFlip, stallSet} = 5'h00;
        unique case (state_r)
            ST_IDLE: begin
                if (accept && link.tokPid == PID_SETUP && rxStat_r != STAT_DISABLED) begin
                    state_nxt = ST_DATA;
                    isSetup_nxt = 1'b1;
                end else if (accept && (link.tokPid == PID_OUT || link.tokPid == PID_IN)) begin
                    // an in token looks at the transmit state, an out token at the receive state
                    unique case ((link.tokPid == PID_IN) ? txStat_r : rxStat_r)
                        STAT_STALL: begin
                            ansValid_nxt = 1'b1;
                            ansKind_nxt = ANS_STALL;
                            stallSet = 1'b1;
                        end
                        STAT_NAK: begin
                            ansValid_nxt = 1'b1;
                            ansKind_nxt = ANS_NAK;
                        end
                        STAT_VALID: begin
                            ansValid_nxt = (link.tokPid == PID_IN);
                            ansKind_nxt = txTog_r ? ANS_DATA1 : ANS_DATA0;
                            state_nxt = (link.tokPid == PID_IN) ? ST_ACK : ST_DATA;
                            isSetup_nxt = 1'b0;
                        end
                        STAT_DISABLED: state_nxt = ST_IDLE;
                    endcase
                end
            end
            ST_DATA: begin
                if (link.dataValid) begin
                    state_nxt = ST_IDLE;
                    // a corrupted packet gets no handshake at all
                    if (link.dataGood) begin
                        ansValid_nxt = 1'b1;
                        ansKind_nxt = ANS_ACK;
                        if (isSetup_r) begin
                            {doneEv, setupEv} = 2'h3;
                        end else if (link.dataPid1 == rxTog_r) begin
                            {doneEv, rxFlip} = 2'h3;
                        end
                    end
                end else if (link.tokValid) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_ACK: begin
                if (link.hostAck) begin
                    state_nxt = ST_IDLE;
                    {doneEv, txFlip} = 2'h3;
                end else if (link.tokValid || link.dataValid) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst || linkReset) begin
            state_r <= ST_IDLE;
            isSetup_r <= 1'b0;
            curPid_r <= 4'h0;
            ansValid_r <= 1'b0;
            ansKind_r <= ANS_NAK;
        end else begin
            state_r <= state_nxt;
            isSetup_r <= isSetup_nxt;
            ansValid_r <= ansValid_nxt;
            ansKind_r <= ansKind_nxt;
            if (accept) begin
                curPid_r <= link.tokPid;
            end
        end
    end

    assign link.ansValid = ansValid_r;
    assign link.ansKind = ansKind_r;

    // control pipe register; hardware updates follow the software write and win
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pDone_r <= 1'b0;
        end else if (doneEv) begin
            pDone_r <= 1'b1;
        end else if (wrPipe) begin
            pDone_r <= pDone_r & regWdata[7];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || linkReset) begin
            {txTog_r, txStat_r, rxTog_r, rxStat_r} <= 6'h00;
        end else begin
            if (wrPipe) begin
                {txTog_r, txStat_r} <= regWdata[6:4];
                {rxTog_r, rxStat_r} <= regWdata[2:0];
            end
            if (doneEv) begin
                txStat_r <= STAT_NAK;
                rxStat_r <= STAT_NAK;
            end
            if (setupEv) begin
                txTog_r <= 1'b1;
                rxTog_r <= 1'b0;
            end
            if (rxFlip) begin
                rxTog_r <= ~rxTog_r;
            end
            if (txFlip) begin
                txTog_r <= ~txTog_r;
            end
            if (stallSet) begin
                txStat_r <= STAT_STALL;
                rxStat_r <= STAT_STALL;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: data one cycle after the strobe, unmapped offsets read zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regRdata_r <= 8'h00;
        end else if (regRd) begin
            unique case (regAddr)
                REG_EVENT_FLAGS: regRdata_r <= flagView;
                REG_EVENT_ENABLES: regRdata_r <= enables_r;
                REG_LINK_CONTROL: regRdata_r <= {resumeSeen_r, rstSeen_r, 2'h0, resumeBit_r,
                    regOff_r, forceSleep_r, forceReset_r};
                REG_NODE_ID: regRdata_r <= {1'b0, nodeId_r};
                REG_TRANSFER_STATUS: regRdata_r <= {statPid_r, statDir_r, statEp_r, statErr_r};
                REG_CONTROL_PIPE: regRdata_r <= {pDone_r, txTog_r, txStat_r, 1'b0, rxTog_r,
                    rxStat_r};
                default: regRdata_r <= 8'h00;
            endcase
        end else begin
            regRdata_r <= 8'h00;
        end
    end

    assign regRdata = regRdata_r;
endmodule

/* File: hdl/ufec_host.sv */
// host controller end: puts tokens, data, handshakes and line states on the link
`timescale 1ns/10ps
module ufec_host
    import ufec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    ufec_link_if.host link,
    input wire logic sendValid,
    input wire logic [2:0] sendKind,
    input wire logic [3:0] sendPid,
    input wire logic [6:0] sendAddr,
    input wire logic [1:0] sendEp,
    input wire logic sendData1,
    input wire logic sendGood,
    input wire logic [2:0] sendErr,
    input wire logic busIdle,
    input wire logic busReset,
    input wire logic busResume,
    output logic ansValid,
    output logic [2:0] ansKind,
    output logic deviceResuming,
    output logic deviceRegOff
);
    logic tokValid_r, dataValid_r, hostAck_r, sofValid_r, errValid_r;
    logic [3:0] tokPid_r;
    logic [6:0] tokAddr_r;
    logic [1:0] tokEp_r;
    logic dataPid1_r, dataGood_r;
    logic [2:0] errCode_r;
    logic lineIdle_r, resetSeq_r, resumeSeq_r;
    logic ansValid_r, resuming_r, regOff_r;
    logic [2:0] ansKind_r;

    ////////////////////////////////////////////////////////////////////////////
    // one-cycle link items, one kind per user request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {tokValid_r, dataValid_r, hostAck_r, sofValid_r, errValid_r} <= 5'h00;
            {tokPid_r, tokAddr_r, tokEp_r} <= 13'h0000;
            {dataPid1_r, dataGood_r, errCode_r} <= 5'h00;
        end else begin
            tokValid_r <= sendValid && (sendKind == KIND_TOKEN);
            dataValid_r <= sendValid && (sendKind == KIND_DATA);
            // the host answers only with acknowledge, never nak or stall
            hostAck_r <= sendValid && (sendKind == KIND_ACK);
            errValid_r <= sendValid && (sendKind == KIND_ERR);
            sofValid_r <= sendValid && (sendKind == KIND_SOF);
            if (sendValid) begin
                {tokPid_r, tokAddr_r, tokEp_r} <= {sendPid, sendAddr, sendEp};
                {dataPid1_r, dataGood_r, errCode_r} <= {sendData1, sendGood, sendErr};
            end
        end
    end

    // line states held as levels; reset shows idle line, no sequences
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {lineIdle_r, resetSeq_r, resumeSeq_r} <= 3'h4;
        end else begin
            {lineIdle_r, resetSeq_r, resumeSeq_r} <= {busIdle, busReset, busResume};
        end
    end

    assign link.tokValid = tokValid_r;
    assign link.tokPid = tokPid_r;
    assign link.tokAddr = tokAddr_r;
    assign link.tokEp = tokEp_r;
    assign link.dataValid = dataValid_r;
    assign link.dataPid1 = dataPid1_r;
    assign link.dataGood = dataGood_r;
    assign link.hostAck = hostAck_r;
    assign link.sofValid = sofValid_r;
    assign link.errValid = errValid_r;
    assign link.errCode = errCode_r;
    assign link.lineIdle = lineIdle_r;
    assign link.resetSeq = resetSeq_r;
    assign link.resumeSeq = resumeSeq_r;

    ////////////////////////////////////////////////////////////////////////////
    // device answers and wake signalling seen by the host
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {ansValid_r, ansKind_r, resuming_r, regOff_r} <= 6'h00;
        end else begin
            ansValid_r <= link.ansValid;
            if (link.ansValid) begin
                ansKind_r <= link.ansKind;
            end
            resuming_r <= link.resumeDrive;
            regOff_r <= link.regOff;
        end
    end

    assign ansValid = ansValid_r;
    assign ansKind = ansKind_r;
    assign deviceResuming = resuming_r;
    assign deviceRegOff = regOff_r;
endmodule

/* File: testbench/ufec_properties.sv */
// link-level assertions between the host end and the function end
`timescale 1ns/10ps
module ufec_properties
    import ufec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tokValid,
    input wire logic [3:0] tokPid,
    input wire logic dataValid,
    input wire logic dataGood,
    input wire logic resetSeq,
    input wire logic ansValid,
    input wire ufec_ans_t ansKind,
    input wire logic regOff
);
    // single clock domain, so one clocking and one disable for all
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    reg_off_reset_a: assert property ($fell(rst) |-> regOff)
        else $error("regulator not off after reset");
    settle_quiet_a: assert property ($fell(regOff) |-> !ansValid [*8])
        else $error("answer during regulator settle");
    off_quiet_a: assert property ($past(regOff) |-> !ansValid)
        else $error("answer with regulator off");
    reset_quiet_a: assert property (resetSeq && $past(resetSeq) |-> !ansValid)
        else $error("answer while link in reset");
    answer_cause_a: assert property (ansValid |-> $past(tokValid || dataValid))
        else $error("answer without an item");
    bad_crc_a: assert property ($past(dataValid && !dataGood) |-> !ansValid)
        else $error("answer to corrupt data");
    ack_data_a: assert property (ansValid && ansKind == ANS_ACK |-> $past(dataValid))
        else $error("ack not after data");
    data_in_a: assert property (ansValid && ansKind inside {ANS_DATA0, ANS_DATA1}
        |-> $past(tokValid && tokPid == PID_IN)) else $error("data not after in token");
    stall_tok_a: assert property (ansValid && ansKind == ANS_STALL |-> $past(tokValid))
        else $error("stall not after token");
endmodule

/* File: testbench/tb.sv */
// both ends joined by the link, driven from the cpu port and the host user side
`timescale 1ns/10ps
`define CK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module tb;
    import ufec_pkg::*;
    logic clk_sys, rst, regWr, regRd, cpuIntMask, pDone, pIn, sendValid, sendData1, sendGood;
    logic busIdle, busReset, busResume, ansValid, deviceResuming, deviceRegOff, irqMain, irqWake;
    logic [7:0] regWdata, regRdata, rv;
    logic [2:0] regAddr, sendKind, ansKind;
    logic [3:0] sendPid;
    logic [1:0] pEp;
    logic pRst;
    int failures = 0, samples_checked = 0, nAns = 0;
    ufec_link_if lnk();
    ufec_device #(.IDLE_CYCLES(20)) ufec_device_i (.clk_sys, .rst, .link(lnk), .regAddr,
        .regWdata, .regWr, .regRd, .regRdata, .cpuIntMask, .pipeCtrPending(1'b0), .pipeDone(pDone),
        .pipeDoneEp(pEp), .pipeDoneIn(pIn), .irqMain, .irqWake, .pipeReset(pRst));
    ufec_host ufec_host_i (.clk_sys, .rst, .link(lnk), .sendValid, .sendKind, .sendPid,
        .sendAddr(7'h05), .sendEp(2'h0), .sendData1, .sendGood, .sendErr(3'h2), .busIdle,
        .busReset, .busResume, .ansValid, .ansKind, .deviceResuming, .deviceRegOff);
    ufec_properties ufec_properties_i (.clk_sys, .rst, .tokValid(lnk.tokValid),
        .tokPid(lnk.tokPid), .dataValid(lnk.dataValid), .dataGood(lnk.dataGood),
        .resetSeq(lnk.resetSeq), .ansValid(lnk.ansValid), .ansKind(lnk.ansKind),
        .regOff(lnk.regOff));
    ////////////////////////////////////////////////////////////////////////////////
    // free-running clock and a count of answers seen by the host
    initial begin clk_sys = 0; forever #10 clk_sys = ~clk_sys; end
    always @(posedge clk_sys) if (ansValid === 1'b1) nAns <= nAns + 1;
    task t(int n); repeat (n) @(posedge clk_sys); #1; endtask
    // strobes drop at the sampling edge so the next call never lands in the same step
    task wr(input logic [2:0] a, input logic [7:0] d);
        regAddr <= a; regWdata <= d; regWr <= 1; @(posedge clk_sys); regWr <= 0; #1;
    endtask
    task rd(input logic [2:0] a);
        regAddr <= a; regRd <= 1; @(posedge clk_sys); regRd <= 0; #1 rv = regRdata;
    endtask
    task snd(input logic [2:0] k, input logic [3:0] p, input logic d1, input logic g);
        sendKind <= k; sendPid <= p; sendData1 <= d1; sendGood <= g; sendValid <= 1;
        @(posedge clk_sys); sendValid <= 0; t(4);
    endtask
    task give_verdict;
        if (failures == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // a few hundred cycles are expected, so this is generous
    initial begin #100000; failures++; give_verdict; end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, regWr, regRd, cpuIntMask, pDone, pIn, sendValid, sendData1, sendGood} = 9'h100;
        {busIdle, busReset, busResume, regWdata, regAddr, sendKind, sendPid, pEp} = '0;
        repeat (2) @(posedge clk_sys); rst <= 0; #1;
        rd(2); `CK(rv, 8'h06)
        rd(1); `CK(rv, 8'h00)
        wr(1, 8'hff); rd(1); `CK(rv, 8'hbf)
        wr(3, 8'h85); rd(3); `CK(rv, 8'h05)
        busReset <= 1; t(3); `CK(pRst, 1'b1)
        busReset <= 0; t(2);
        rd(3); `CK(rv, 8'h00)
        rd(0); `CK(rv[1], 1'b1)
        `CK(irqMain, 1'b1)
        cpuIntMask <= 1; t(1); `CK(irqMain, 1'b0)
        cpuIntMask <= 0; wr(2, 8'h00); t(160); wr(3, 8'h05);
        snd(0, PID_IN, 0, 1); `CK(nAns, 0)
        wr(5, 8'h33); snd(0, PID_SETUP, 0, 1); snd(1, 0, 0, 1); `CK(ansKind, ANS_ACK)
        rd(5); `CK(rv, 8'he2)
        rd(4); `CK(rv[7:6], 2'b11)
        rd(0); `CK(rv[7], 1'b1)
        wr(5, 8'h70); snd(0, PID_IN, 0, 1); `CK(ansKind, ANS_DATA1)
        snd(2, 0, 0, 1); rd(5); `CK(rv, 8'ha2)
        rd(4); `CK(rv[7:6], 2'b10)
        wr(5, 8'h10); snd(0, PID_IN, 0, 1); `CK(ansKind, ANS_STALL)
        rd(5); `CK(rv, 8'h11)
        wr(5, 8'h03); snd(0, PID_OUT, 0, 1); snd(1, 0, 0, 0); `CK(nAns, 3)
        snd(0, PID_OUT, 0, 1); snd(1, 0, 0, 1); rd(5); `CK(rv, 8'ha6)
        rd(4); `CK(rv[7:6], 2'b00)
        wr(0, 8'h00); snd(4, 0, 0, 1); snd(3, 0, 0, 1);
        rd(0); `CK(rv[4], 1'b1)
        `CK(rv[0], 1'b1)
        rd(4); `CK(rv[2:0], 3'h2)
        wr(0, 8'hef); rd(4); `CK(rv[2:0], 3'h0)
        rd(0); `CK(rv[0], 1'b1)
        pDone <= 1; pEp <= 2'h2; pIn <= 1; t(1); pDone <= 0; t(1);
        rd(4); `CK(rv[5:3], 3'b110)
        wr(0, 8'h00); wr(2, 8'h01); `CK(pRst, 1'b1)
        wr(2, 8'h00); t(1); rd(0); `CK(rv[1], 1'b1)
        wr(0, 8'h00); busIdle <= 1; t(30); rd(0); `CK(rv[3], 1'b1)
        busIdle <= 0; t(2); busIdle <= 1; t(2); wr(2, 8'h02); wr(0, 8'h00);
        t(30); rd(0); `CK(rv[3], 1'b0)
        busResume <= 1; busIdle <= 0; t(3); `CK(irqWake, 1'b1)
        rd(2); `CK(rv, 8'h80)
        busResume <= 0; busIdle <= 1; t(2);
        wr(2, 8'h0a); t(3); `CK(deviceResuming, 1'b1)
        wr(2, 8'h04); t(3); `CK(deviceRegOff, 1'b1)
        `CK(deviceResuming, 1'b0)
        give_verdict;
    end
endmodule
